// File: design/cct_pkg.sv
// package: map, field layout and reset values of the compare timer
package cct_pkg;

	// register byte addresses on the 16-bit peripheral address bus
	localparam logic [15:0] ADDR_CLOCK_AND_OUTPUT_CTRL = 16'hffb6;
	localparam logic [15:0] ADDR_FLAGS_AND_CLEAR_CTRL = 16'hffb7;
	localparam logic [15:0] ADDR_UPPER_COUNTER = 16'hffb8;
	localparam logic [15:0] ADDR_LOWER_COUNTER = 16'hffb9;
	localparam logic [15:0] ADDR_UPPER_COMPARE = 16'hffba;
	localparam logic [15:0] ADDR_LOWER_COMPARE = 16'hffbb;

	// flags and clear control bit positions
	localparam int BIT_HIGH_OVERFLOW_FLAG = 7;
	localparam int BIT_HIGH_MATCH_FLAG = 6;
	localparam int BIT_HIGH_OVERFLOW_IRQ_EN = 5;
	localparam int BIT_HIGH_MATCH_CLEAR_EN = 4;
	localparam int BIT_LOW_OVERFLOW_FLAG = 3;
	localparam int BIT_LOW_MATCH_FLAG = 2;
	localparam int BIT_LOW_OVERFLOW_IRQ_EN = 1;
	localparam int BIT_LOW_MATCH_CLEAR_EN = 0;

	// reset values
	localparam logic [7:0] RESET_FLAGS = 8'h00;
	localparam logic [7:0] RESET_CTRL = 8'h00;
	localparam logic [7:0] RESET_COUNTER = 8'h00;
	localparam logic [7:0] RESET_COMPARE = 8'hff;
	// value returned for write-only or unmapped reads
	localparam logic [7:0] READ_IDLE = 8'hff;

	// prescaler: divide ratios 32, 16, 4, 2 need five stage bits
	localparam int PRESCALE_BITS = 5;

	// clock and output control register layout
	typedef struct packed {
		logic high_output_level;
		logic high_mode_select_bit;
		logic [1:0] high_rate;
		logic low_output_level;
		logic low_source_select_bit;
		logic [1:0] low_rate;
	} cct_clkctl_t;

	// peripheral bus request from the cpu
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cct_busreq_t;

endpackage : cct_pkg

// File: design/cct_sync.sv
// three-stage synchroniser for the external event pin with edge detect
`timescale 1ns/10ps
module cct_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic rise,
	output logic fall
);
	logic s1;
	logic s2;
	logic s3;
	logic level;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a change counts once stages two and three agree on the new level,
	// so a one-cycle glitch on the pin never reaches the counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= 1'b0;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end

	assign rise = s2 & s3 & ~level;
	assign fall = ~s2 & ~s3 & level;

endmodule : cct_sync

// File: design/cct_half.sv
// one 8-bit counter half: load, clear, count and wrap detect
`timescale 1ns/10ps
module cct_half (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic clear,
	input wire logic load,
	input wire logic [7:0] load_val,
	output logic [7:0] cnt,
	output logic wrap
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= cct_pkg::RESET_COUNTER;
		end else if (load) begin
			cnt <= load_val;
		end else if (clear) begin
			cnt <= 8'h00;
		end else if (tick) begin
			cnt <= cnt + 8'h01;
		end
	end

	// a cpu write in the same cycle swallows the wrap
	assign wrap = tick & ~clear & ~load & (cnt == 8'hff);

endmodule : cct_half

// File: design/cct_timer.sv
// cascadable 16-bit or dual 8-bit compare timer with cpu byte interface
//
// Operation
// - hardware sets overflow flags on wrap only
// - flags clear by zero write after read
// - upper match sets high match flag
// - lower match sets low match flag
// - per-half overflow interrupt enable bits
// - high clear bit clears on match
// - low clear bit clears lower on match
// - reset values for all registers
// - upper write staged, lower write commits both
// - upper counter read latches lower byte
// - compare reads bypass the staging latch
// - 8-bit mode allows any access order
// - mode bit zero cascades halves
// - 16-bit wrap sets high overflow flag
// - 16-bit match flags, toggles, requests, clears
// - 8-bit halves overflow independently
// - count on selected divided clock pulse
// - external edge counting, two-cycle pulses
// - toggle pins invert on match
// - match signalled leaving the matching count
// - counter halts outside active and sleep
// - clock select encoding of rate fields
// - output level write drives pin immediately
`timescale 1ns/10ps
module cct_timer (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic RUN_EN,
	input wire logic EVENT_COUNT_INPUT,
	input wire logic EVENT_EDGE_SELECT,
	input wire logic HIGH_IRQ_GATE,
	input wire logic LOW_IRQ_GATE,
	output logic HIGH_IRQ_REQ,
	output logic LOW_IRQ_REQ,
	output logic HIGH_TOGGLE_PIN,
	output logic LOW_TOGGLE_PIN
);
	cct_pkg::cct_busreq_t bus;
	cct_pkg::cct_clkctl_t clock_and_output_ctrl;
	logic [7:0] timer_flags_and_clear_ctrl;
	logic [7:0] flag_armed;
	logic [7:0] staging_latch;
	logic [7:0] upper_compare_value;
	logic [7:0] lower_compare_value;
	logic [7:0] upper_counter;
	logic [7:0] lower_counter;
	logic [15:0] wide_counter;
	logic [15:0] wide_compare_value;
	logic [cct_pkg::PRESCALE_BITS-1:0] prescale;
	logic ev_rise;
	logic ev_fall;
	logic ev_edge;
	logic wide_mode;
	logic tick_l;
	logic tick_h;
	logic wrap_l;
	logic wrap_h;
	logic match_l;
	logic match_h8;
	logic match_16;
	logic match_h;
	logic clear_h;
	logic clear_l;
	logic sel_ctrl;
	logic sel_flags;
	logic sel_cnt_h;
	logic sel_cnt_l;
	logic sel_cmp_h;
	logic sel_cmp_l;
	logic wr_ctrl;
	logic wr_flags;
	logic wr_cnt_h;
	logic wr_cnt_l;
	logic wr_cmp_h;
	logic wr_cmp_l;
	logic load_h;
	logic load_l;
	logic [7:0] load_val_h;
	logic [7:0] next_flags;
	logic [7:0] flag_set;
	cct_pkg::cct_clkctl_t ctl_wdata;

	assign bus.addr = ADDR;
	assign bus.wdata = WDATA;
	assign bus.wr = WR;
	assign bus.rd = RD;
	assign ctl_wdata = bus.wdata;

	// address decode
	assign sel_ctrl = bus.addr == cct_pkg::ADDR_CLOCK_AND_OUTPUT_CTRL;
	assign sel_flags = bus.addr == cct_pkg::ADDR_FLAGS_AND_CLEAR_CTRL;
	assign sel_cnt_h = bus.addr == cct_pkg::ADDR_UPPER_COUNTER;
	assign sel_cnt_l = bus.addr == cct_pkg::ADDR_LOWER_COUNTER;
	assign sel_cmp_h = bus.addr == cct_pkg::ADDR_UPPER_COMPARE;
	assign sel_cmp_l = bus.addr == cct_pkg::ADDR_LOWER_COMPARE;
	assign wr_ctrl = bus.wr & sel_ctrl;
	assign wr_flags = bus.wr & sel_flags;
	assign wr_cnt_h = bus.wr & sel_cnt_h;
	assign wr_cnt_l = bus.wr & sel_cnt_l;
	assign wr_cmp_h = bus.wr & sel_cmp_h;
	assign wr_cmp_l = bus.wr & sel_cmp_l;

	assign wide_mode = ~clock_and_output_ctrl.high_mode_select_bit;
	assign wide_counter = {upper_counter, lower_counter};
	assign wide_compare_value = {upper_compare_value, lower_compare_value};

	// free-running prescaler; it keeps running while the counter halts
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + 5'h01;
		end
	end

	// one-cycle pulse at the selected rate: /32, /16, /4, /2
	function automatic logic rate_tick(input logic [1:0] sel,
		input logic [cct_pkg::PRESCALE_BITS-1:0] pre);
		logic t;
		t = 1'b0;
		unique case (sel)
			2'b00: t = (pre[4:0] == 5'h1f);
			2'b01: t = (pre[3:0] == 4'hf);
			2'b10: t = (pre[1:0] == 2'h3);
			2'b11: t = pre[0];
		endcase
		return t;
	endfunction : rate_tick

	cct_sync u_event_sync (
		.clk(CLK_SYS),
		.rst(RST),
		.din(EVENT_COUNT_INPUT),
		.rise(ev_rise),
		.fall(ev_fall)
	);

	// edge polarity comes from the interrupt controller's edge select
	assign ev_edge = EVENT_EDGE_SELECT ? ev_rise : ev_fall;

	// lower half source: external edge or divided clock
	assign tick_l = RUN_EN & (clock_and_output_ctrl.low_source_select_bit ?
		rate_tick(clock_and_output_ctrl.low_rate, prescale) :
		ev_edge);

	// upper half: counts lower wraps when cascaded
	assign tick_h = RUN_EN & (wide_mode ? wrap_l :
		rate_tick(clock_and_output_ctrl.high_rate, prescale));

	// matches fire on the tick that leaves the matching value; a compare
	// write in the same cycle inhibits that match
	assign match_l = tick_l & ~wr_cmp_l &
		(lower_counter == lower_compare_value);
	assign match_h8 = tick_h & ~wr_cmp_h &
		(upper_counter == upper_compare_value);
	assign match_16 = tick_l & ~wr_cmp_l &
		(wide_counter == wide_compare_value);
	assign match_h = wide_mode ? match_16 : match_h8;

	assign clear_h = match_h &
		timer_flags_and_clear_ctrl[cct_pkg::BIT_HIGH_MATCH_CLEAR_EN];
	// in wide mode the high clear zeroes both halves together
	assign clear_l = (wide_mode & clear_h) | (match_l &
		timer_flags_and_clear_ctrl[cct_pkg::BIT_LOW_MATCH_CLEAR_EN]);

	// 16-bit writes stage the upper byte; the lower write commits both
	assign load_h = wide_mode ? wr_cnt_l : wr_cnt_h;
	assign load_l = wr_cnt_l;
	assign load_val_h = wide_mode ? staging_latch : bus.wdata;

	cct_half u_lower (
		.clk(CLK_SYS),
		.rst(RST),
		.tick(tick_l),
		.clear(clear_l),
		.load(load_l),
		.load_val(bus.wdata),
		.cnt(lower_counter),
		.wrap(wrap_l)
	);

	cct_half u_upper (
		.clk(CLK_SYS),
		.rst(RST),
		.tick(tick_h),
		.clear(clear_h & ~load_h),
		.load(load_h),
		.load_val(load_val_h),
		.cnt(upper_counter),
		.wrap(wrap_h)
	);

	// staging latch: upper writes in wide mode, upper counter reads
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			staging_latch <= 8'h00;
		end else if (wide_mode & (wr_cnt_h | wr_cmp_h)) begin
			staging_latch <= bus.wdata;
		end else if (wide_mode & bus.rd & sel_cnt_h) begin
			staging_latch <= lower_counter;
		end
	end

	// compare registers
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			upper_compare_value <= cct_pkg::RESET_COMPARE;
			lower_compare_value <= cct_pkg::RESET_COMPARE;
		end else begin
			if (wide_mode & wr_cmp_l) begin
				upper_compare_value <= staging_latch;
			end else if (~wide_mode & wr_cmp_h) begin
				upper_compare_value <= bus.wdata;
			end
			if (wr_cmp_l) begin
				lower_compare_value <= bus.wdata;
			end
		end
	end

	// clock and output control
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			clock_and_output_ctrl <= cct_pkg::RESET_CTRL;
		end else if (wr_ctrl) begin
			clock_and_output_ctrl <= bus.wdata;
		end
	end

	// hardware set events per flag bit
	always_comb begin
		flag_set = 8'h00;
		flag_set[cct_pkg::BIT_HIGH_OVERFLOW_FLAG] = wrap_h;
		flag_set[cct_pkg::BIT_HIGH_MATCH_FLAG] = match_h;
		flag_set[cct_pkg::BIT_LOW_OVERFLOW_FLAG] = wrap_l;
		flag_set[cct_pkg::BIT_LOW_MATCH_FLAG] = match_l;
	end

	// flags take only a zero write, and only after being read as one;
	// a set arriving in the clearing cycle wins
	always_comb begin
		next_flags = timer_flags_and_clear_ctrl;
		if (wr_flags) begin
			next_flags[cct_pkg::BIT_HIGH_OVERFLOW_IRQ_EN] =
				bus.wdata[cct_pkg::BIT_HIGH_OVERFLOW_IRQ_EN];
			next_flags[cct_pkg::BIT_HIGH_MATCH_CLEAR_EN] =
				bus.wdata[cct_pkg::BIT_HIGH_MATCH_CLEAR_EN];
			next_flags[cct_pkg::BIT_LOW_OVERFLOW_IRQ_EN] =
				bus.wdata[cct_pkg::BIT_LOW_OVERFLOW_IRQ_EN];
			next_flags[cct_pkg::BIT_LOW_MATCH_CLEAR_EN] =
				bus.wdata[cct_pkg::BIT_LOW_MATCH_CLEAR_EN];
			for (int i = 0; i < 8; i++) begin
				if (flag_armed[i] & ~bus.wdata[i]) begin
					next_flags[i] = 1'b0;
				end
			end
		end
		next_flags = next_flags | flag_set;
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			timer_flags_and_clear_ctrl <= cct_pkg::RESET_FLAGS;
		end else begin
			timer_flags_and_clear_ctrl <= next_flags;
		end
	end

	// arm a flag for clearing when software reads it as one
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			flag_armed <= 8'h00;
		end else if (wr_flags) begin
			flag_armed <= 8'h00;
		end else if (bus.rd & sel_flags) begin
			flag_armed <= flag_armed | (timer_flags_and_clear_ctrl & {
				1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0});
		end
	end

	// toggle pins: a control write beats a simultaneous match
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			HIGH_TOGGLE_PIN <= 1'b0;
			LOW_TOGGLE_PIN <= 1'b0;
		end else if (wr_ctrl) begin
			HIGH_TOGGLE_PIN <= ctl_wdata.high_output_level;
			LOW_TOGGLE_PIN <= ctl_wdata.low_output_level;
		end else begin
			if (match_h) begin
				HIGH_TOGGLE_PIN <= ~HIGH_TOGGLE_PIN;
			end
			// the low pin still toggles on lower byte matches in wide mode
			if (match_l) begin
				LOW_TOGGLE_PIN <= ~LOW_TOGGLE_PIN;
			end
		end
	end

	// interrupt request pulses towards the interrupt controller
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			HIGH_IRQ_REQ <= 1'b0;
			LOW_IRQ_REQ <= 1'b0;
		end else begin
			HIGH_IRQ_REQ <= HIGH_IRQ_GATE & (match_h | (wrap_h &
				timer_flags_and_clear_ctrl[
				cct_pkg::BIT_HIGH_OVERFLOW_IRQ_EN]));
			LOW_IRQ_REQ <= LOW_IRQ_GATE & ((~wide_mode & match_l) |
				(wrap_l & timer_flags_and_clear_ctrl[
				cct_pkg::BIT_LOW_OVERFLOW_IRQ_EN]));
		end
	end

	// registered read data, valid the cycle after the read strobe
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (bus.rd) begin
			if (sel_flags) begin
				RDATA <= timer_flags_and_clear_ctrl;
			end else if (sel_cnt_h) begin
				RDATA <= upper_counter;
			end else if (sel_cnt_l) begin
				RDATA <= wide_mode ? staging_latch : lower_counter;
			end else if (sel_cmp_h) begin
				RDATA <= upper_compare_value;
			end else if (sel_cmp_l) begin
				RDATA <= lower_compare_value;
			end else begin
				// control register is write-only
				RDATA <= cct_pkg::READ_IDLE;
			end
		end
	end

endmodule : cct_timer

// File: dv/cct_timer_props.sv
// checker: port-level timing properties of the compare timer
`timescale 1ns/10ps
module cct_timer_props (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic RUN_EN,
	input wire logic HIGH_IRQ_GATE,
	input wire logic LOW_IRQ_GATE,
	input wire logic HIGH_IRQ_REQ,
	input wire logic LOW_IRQ_REQ,
	input wire logic HIGH_TOGGLE_PIN,
	input wire logic LOW_TOGGLE_PIN
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	logic ctl_wr;
	logic [7:0] wd_q;
	assign ctl_wr = WR && ADDR == cct_pkg::ADDR_CLOCK_AND_OUTPUT_CTRL;
	always_ff @(posedge CLK_SYS) begin
		wd_q <= WDATA;
	end
	// three idle cycles leave no tick in flight toward pins or requests
	sequence halted_s;
		(!RUN_EN && !WR) [*3];
	endsequence
	sequence ctl_read_s;
		RD && ADDR == cct_pkg::ADDR_CLOCK_AND_OUTPUT_CTRL;
	endsequence
	chk_reset_quiet: assert property (
		disable iff (1'b0) RST |-> RDATA == 8'h00 && !HIGH_TOGGLE_PIN)
		else $error("output active in reset");
	chk_rdata_holds: assert property (!RD |=> $stable(RDATA))
		else $error("read data moved without a read");
	chk_ctrl_pins: assert property (ctl_wr |=>
		HIGH_TOGGLE_PIN == wd_q[7] && LOW_TOGGLE_PIN == wd_q[3])
		else $error("pin level not taken from control write");
	chk_ctrl_idle: assert property (ctl_read_s |=> RDATA == 8'hff)
		else $error("control read not idle value");
	chk_toggle_irq: assert property ($changed(HIGH_TOGGLE_PIN) &&
		!$past(ctl_wr) && $past(HIGH_IRQ_GATE) |-> HIGH_IRQ_REQ)
		else $error("toggle without match request");
	chk_high_gate: assert property (HIGH_IRQ_REQ |-> $past(HIGH_IRQ_GATE))
		else $error("high request while gated");
	chk_low_gate: assert property (LOW_IRQ_REQ |-> $past(LOW_IRQ_GATE))
		else $error("low request while gated");
	chk_irq_pulse: assert property (HIGH_IRQ_REQ |=> !HIGH_IRQ_REQ)
		else $error("high request longer than one cycle");
	chk_halt_quiet: assert property (halted_s |->
		$stable(HIGH_TOGGLE_PIN) && !HIGH_IRQ_REQ && !LOW_IRQ_REQ)
		else $error("activity while halted");
endmodule : cct_timer_props
bind cct_timer cct_timer_props u_props (.CLK_SYS(CLK_SYS), .RST(RST),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.RUN_EN(RUN_EN), .HIGH_IRQ_GATE(HIGH_IRQ_GATE),
	.LOW_IRQ_GATE(LOW_IRQ_GATE), .HIGH_IRQ_REQ(HIGH_IRQ_REQ),
	.LOW_IRQ_REQ(LOW_IRQ_REQ), .HIGH_TOGGLE_PIN(HIGH_TOGGLE_PIN),
	.LOW_TOGGLE_PIN(LOW_TOGGLE_PIN));

// File: dv/cct_cpu.sv
// cpu side model of the 8-bit peripheral bus
`timescale 1ns/10ps
module cct_cpu (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output logic [15:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);
	initial begin
		addr = 16'h0000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// idle bus shows inverted values so stale data never looks valid
	task automatic wr8(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask : wr8
	task automatic rd8(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		// registered data stands from this edge; take it mid-cycle
		@(negedge clk);
		d = rdata;
	endtask : rd8
	// wide values go upper byte first so the staging latch pairs them
	task automatic wr16(input logic [15:0] a, input logic [15:0] d);
		wr8(a, d[15:8]);
		wr8(a + 16'h0001, d[7:0]);
	endtask : wr16
	task automatic rd16(input logic [15:0] a, output logic [15:0] d);
		rd8(a, d[15:8]);
		rd8(a + 16'h0001, d[7:0]);
	endtask : rd16
endmodule : cct_cpu

// File: dv/cct_timer_tb.sv
// self-checking bench for the compare timer
`timescale 1ns/10ps
`define CCT_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module cct_timer_tb;
	localparam logic [15:0] a_ctl = cct_pkg::ADDR_CLOCK_AND_OUTPUT_CTRL;
	localparam logic [15:0] a_flg = cct_pkg::ADDR_FLAGS_AND_CLEAR_CTRL;
	localparam logic [15:0] a_cnt = cct_pkg::ADDR_UPPER_COUNTER;
	localparam logic [15:0] a_cmp = cct_pkg::ADDR_UPPER_COMPARE;
	logic clk_sys, rst, run_en, evt, evt_sel, wr, rd;
	logic hi_irq, lo_irq, hi_pin, lo_pin, last_pin;
	logic hi_gate, lo_gate, last_lo;
	logic [15:0] addr;
	logic [7:0] wdata, rdata;
	int num_errors = 0;
	int total_checks = 0;
	int hi_n = 0;
	int tog_n = 0;
	int lo_n = 0;
	int lt_n = 0;
	cct_cpu u_cpu (.clk(clk_sys), .rdata(rdata), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd));
	cct_timer u_dut (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RUN_EN(run_en),
		.EVENT_COUNT_INPUT(evt), .EVENT_EDGE_SELECT(evt_sel),
		.HIGH_IRQ_GATE(hi_gate), .LOW_IRQ_GATE(lo_gate), .HIGH_IRQ_REQ(hi_irq),
		.LOW_IRQ_REQ(lo_irq), .HIGH_TOGGLE_PIN(hi_pin),
		.LOW_TOGGLE_PIN(lo_pin));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// counted at the falling edge, clear of the launching edge
	always @(negedge clk_sys) begin
		if (hi_irq === 1'b1)
			hi_n++;
		if (hi_pin !== last_pin)
			tog_n++;
		last_pin = hi_pin;
		if (lo_irq === 1'b1)
			lo_n++;
		if (lo_pin !== last_lo)
			lt_n++;
		last_lo = lo_pin;
	end
	task automatic run(input int n);
		@(posedge clk_sys);
		run_en <= 1'b1;
		repeat (n) @(posedge clk_sys);
		run_en <= 1'b0;
	endtask : run
	task automatic t_reset;
		logic [7:0] d;
		logic [7:0] ev [7] = '{8'hff, 0, 0, 0, 8'hff, 8'hff, 8'hff};
		for (int i = 0; i < 7; i++) begin
			u_cpu.rd8(a_ctl + 16'(i), d);
			`CCT_CHK(d, ev[i])
		end
		u_cpu.wr8(a_flg, 8'hff);
		u_cpu.rd8(a_flg, d);
		`CCT_CHK(d, 8'h33)
		u_cpu.wr8(a_flg, 8'h00);
		u_cpu.wr8(a_ctl, 8'h88);
		@(negedge clk_sys);
		`CCT_CHK(({hi_pin, lo_pin}), 2'b11)
	endtask : t_reset
	task automatic t_wide;
		logic [7:0] d;
		logic [15:0] w;
		int b;
		int c;
		u_cpu.wr8(a_ctl, 8'h07);
		u_cpu.wr16(a_cmp, 16'h1234);
		u_cpu.rd8(a_cmp + 16'h0001, d);
		`CCT_CHK(d, 8'h34)
		u_cpu.wr16(a_cnt, 16'haa55);
		u_cpu.wr8(a_cnt, 8'h77);
		u_cpu.rd16(a_cnt, w);
		`CCT_CHK(w, 16'haa55)
		u_cpu.rd8(a_cnt, d);
		run(10);
		u_cpu.rd8(a_cnt + 16'h0001, d);
		`CCT_CHK(d, 8'h55)
		u_cpu.wr8(a_flg, 8'h20);
		u_cpu.wr16(a_cnt, 16'hfffe);
		b = hi_n;
		c = lo_n;
		run(12);
		`CCT_CHK(hi_n - b, 1)
		`CCT_CHK(lo_n - c, 0)
		u_cpu.rd16(a_cnt, w);
		`CCT_CHK(w[15:8], 8'h00)
		u_cpu.rd8(a_flg, d);
		`CCT_CHK(d[7], 1'b1)
		// a zero written without a fresh read must not clear
		u_cpu.wr8(a_flg, 8'ha0);
		u_cpu.wr8(a_flg, 8'h20);
		u_cpu.rd8(a_flg, d);
		`CCT_CHK(d[7], 1'b1)
		u_cpu.wr8(a_flg, 8'h20);
		u_cpu.rd8(a_flg, d);
		`CCT_CHK(d[7], 1'b0)
		// high gate closed: the flag still sets, no high request leaves
		@(posedge clk_sys);
		hi_gate <= 1'b0;
		u_cpu.wr8(a_flg, 8'h22);
		u_cpu.wr16(a_cnt, 16'hfffe);
		b = hi_n;
		c = lo_n;
		run(12);
		`CCT_CHK(hi_n - b, 0)
		`CCT_CHK(lo_n - c, 1)
		u_cpu.rd8(a_flg, d);
		`CCT_CHK(d[7], 1'b1)
		@(posedge clk_sys);
		hi_gate <= 1'b1;
	endtask : t_wide
	task automatic t_match(input logic [7:0] ctl, input logic [15:0] cmp);
		logic [7:0] u, l;
		int h0, t0, l0, p0;
		u_cpu.wr8(a_ctl, ctl);
		if (ctl[6]) begin
			u_cpu.wr8(a_cmp + 16'h0001, cmp[7:0]);
			u_cpu.wr8(a_cmp, cmp[15:8]);
		end else
			u_cpu.wr16(a_cmp, cmp);
		u_cpu.wr16(a_cnt, 16'h0000);
		u_cpu.wr8(a_flg, 8'h11);
		h0 = hi_n;
		t0 = tog_n;
		l0 = lo_n;
		p0 = lt_n;
		repeat (6) begin
			run(7);
			u_cpu.rd8(a_cnt, u);
			u_cpu.rd8(a_cnt + 16'h0001, l);
			if (ctl[6])
				`CCT_CHK(u <= cmp[15:8] && l <= cmp[7:0], 1'b1)
			else
				`CCT_CHK(({u, l} <= cmp), 1'b1)
		end
		`CCT_CHK(hi_n - h0 > 1, 1'b1)
		`CCT_CHK(tog_n - t0, hi_n - h0)
		`CCT_CHK(lt_n - p0 > 1, 1'b1)
		`CCT_CHK(lo_n - l0, ctl[6] ? lt_n - p0 : 0)
		u_cpu.rd8(a_flg, u);
		`CCT_CHK(u & 8'h44, 8'h44)
		if (ctl[6]) begin
			u_cpu.wr8(a_flg, 8'h10);
			run(30);
			u_cpu.rd8(a_cnt + 16'h0001, l);
			`CCT_CHK(l > 8'h03, 1'b1)
		end
	endtask : t_match
	task automatic t_rates;
		logic [7:0] a, b;
		int n;
		int l0;
		// low requests gated off while the low pin still toggles on match
		@(posedge clk_sys);
		lo_gate <= 1'b0;
		l0 = lo_n;
		for (int r = 0; r < 4; r++) begin
			n = 64 / (r == 0 ? 32 : r == 1 ? 16 : r == 2 ? 4 : 2);
			u_cpu.wr8(a_ctl, 8'h44 | 8'(r));
			u_cpu.wr8(a_cnt + 16'h0001, 8'h00);
			run(64);
			u_cpu.rd8(a_cnt + 16'h0001, a);
			u_cpu.rd8(a_cnt + 16'h0001, b);
			`CCT_CHK(a, b)
			`CCT_CHK(a >= 8'(n - 1) && a <= 8'(n + 1), 1'b1)
			`CCT_CHK(lo_pin, r != 0)
		end
		`CCT_CHK(lo_n - l0, 0)
		@(posedge clk_sys);
		lo_gate <= 1'b1;
	endtask : t_rates
	task automatic t_events;
		logic [7:0] d;
		u_cpu.wr8(a_ctl, 8'h40);
		u_cpu.wr8(a_cnt + 16'h0001, 8'h00);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			evt_sel <= !k[0];
			run_en <= 1'b1;
			repeat (5) begin
				@(posedge clk_sys);
				evt <= 1'b1;
				repeat (3) @(posedge clk_sys);
				evt <= 1'b0;
				repeat (2) @(posedge clk_sys);
			end
			repeat (6) @(posedge clk_sys);
			run_en <= 1'b0;
			u_cpu.rd8(a_cnt + 16'h0001, d);
			`CCT_CHK(d, 8'(5 * (k + 1)))
		end
	endtask : t_events
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	initial begin
		rst = 1'b1;
		run_en = 1'b0;
		evt = 1'b0;
		evt_sel = 1'b1;
		last_pin = 1'b0;
		last_lo = 1'b0;
		hi_gate = 1'b1;
		lo_gate = 1'b1;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_wide();
		t_match(8'h07, 16'h0003);
		t_match(8'h77, 16'h0503);
		t_rates();
		t_events();
		// reset again from a busy state: every register must return
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		end_sim();
	end
	initial begin
		repeat (50000) @(posedge clk_sys);
		num_errors++;
		end_sim();
	end
endmodule : cct_timer_tb
